// ### rtl/test_port_defs.vh
/*
  Shared constants for the two boundary-scan test ports: controller state
  codes, instruction codes and the instruction capture pattern.
  Assumes it is included by its bare name from the design file.
*/
`ifndef TEST_PORT_DEFS_VH
`define TEST_PORT_DEFS_VH

// Controller states, four-bit binary codes
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'ha
`define ST_SHIFT_IR   4'hb
`define ST_EXIT1_IR   4'hc
`define ST_PAUSE_IR   4'hd
`define ST_EXIT2_IR   4'he
`define ST_UPD_IR     4'hf

// Instruction register width and codes
`define IR_W          4
`define INSTR_IDCODE  4'h1
`define INSTR_BYPASS  4'hf
// Fixed pattern loaded into the instruction shifter on capture
`define IR_CAPTURE    4'h1

// Identification word width
`define ID_W          32

`endif

// ### rtl/dual_test_ports.v
/*
  Two independent boundary-scan test access ports: one for the mapper core
  and one for the line transceivers. Each has its own controller,
  instruction register, identification and bypass registers.
  Assumes all test pins are asynchronous to clk_sys; the test clocks are
  slow enough (well under a quarter of clk_sys) to be sampled and their
  edges found after a two-flop synchroniser.
*/
// How it works
// - Mapper port: data in on rise, out on fall
// - Mapper mode-select sampled each rising edge
// - Mapper test reset resets controller without clock
// - Reset rising enters ID mode; low gives normal
// - Transceiver port: in on rise, out on fall
// - Transceiver test reset resets controller clocklessly
// - Transceiver reset raise gives ID mode; low normal
// - Data-out pins are three-state, shifted data only
// - Transceiver mode-select sampled each rising edge
`timescale 1ns/1ns
`include "test_port_defs.vh"

module test_port_tap #(
  parameter [`ID_W-1:0] ID_WORD = 32'h00000001 // Arbitrary neutral value
) (
  input wire clk_sys,
  input wire nrst,
  input wire test_clock,
  input wire test_mode_select,
  input wire test_data_in,
  input wire test_reset,
  output reg test_data_out,
  output reg test_data_out_oe,
  output reg id_mode
);

  // Two-flop synchronisers; only stage two is read by logic
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  // Previous synchronised clock and reset, for edge finding
  reg clk_prev_q;
  reg rst_prev_q;
  // Controller state and its next value
  reg [3:0] state_q;
  reg [3:0] state_d;
  // Instruction shifter and held instruction
  reg [`IR_W-1:0] ir_shift_q;
  reg [`IR_W-1:0] ir_q;
  // Identification shifter and bypass bit
  reg [`ID_W-1:0] id_shift_q;
  reg bypass_q;

  wire tck_s = sync2_q[0];
  wire tms_s = sync2_q[1];
  wire tdi_s = sync2_q[2];
  wire trst_s = sync2_q[3];
  wire tck_rise = tck_s & ~clk_prev_q;
  wire tck_fall = ~tck_s & clk_prev_q;
  wire trst_rise = trst_s & ~rst_prev_q;
  wire sel_id = (ir_q == `INSTR_IDCODE);

  // Bring all four pins into the clk_sys domain
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      clk_prev_q <= 1'b0;
      rst_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {test_reset, test_data_in, test_mode_select, test_clock};
      sync2_q <= sync1_q;
      clk_prev_q <= tck_s;
      rst_prev_q <= trst_s;
    end
  end

  // Standard sixteen-state next-state function
  always @*
  begin
    case (state_q)
      `ST_RESET: state_d = tms_s ? `ST_RESET : `ST_IDLE;
      `ST_IDLE: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_DR: state_d = tms_s ? `ST_SEL_IR : `ST_CAP_DR;
      `ST_CAP_DR: state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_SHIFT_DR: state_d = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_EXIT1_DR: state_d = tms_s ? `ST_UPD_DR : `ST_PAUSE_DR;
      `ST_PAUSE_DR: state_d = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
      `ST_EXIT2_DR: state_d = tms_s ? `ST_UPD_DR : `ST_SHIFT_DR;
      `ST_UPD_DR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
      `ST_SEL_IR: state_d = tms_s ? `ST_RESET : `ST_CAP_IR;
      `ST_CAP_IR: state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_SHIFT_IR: state_d = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_EXIT1_IR: state_d = tms_s ? `ST_UPD_IR : `ST_PAUSE_IR;
      `ST_PAUSE_IR: state_d = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
      `ST_EXIT2_IR: state_d = tms_s ? `ST_UPD_IR : `ST_SHIFT_IR;
      `ST_UPD_IR: state_d = tms_s ? `ST_SEL_DR : `ST_IDLE;
      default: state_d = `ST_RESET;
    endcase
  end

  // Controller, registers and test mode flag
  always @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_q <= `ST_RESET;
      ir_q <= `INSTR_IDCODE;
      ir_shift_q <= `IR_CAPTURE;
      id_shift_q <= ID_WORD;
      bypass_q <= 1'b0;
      id_mode <= 1'b0;
    end
    else if (!trst_s)
    begin
      // Held reset: no test clock needed, normal operation
      state_q <= `ST_RESET;
      ir_q <= `INSTR_IDCODE;
      id_mode <= 1'b0;
    end
    else
    begin
      // Rising reset edge enters identification mode
      if (trst_rise)
      begin
        id_mode <= 1'b1;
        state_q <= `ST_RESET;
        ir_q <= `INSTR_IDCODE;
      end
      else if (tck_rise)
      begin
        state_q <= state_d;
        case (state_q)
          `ST_RESET: ir_q <= `INSTR_IDCODE;
          `ST_CAP_IR: ir_shift_q <= `IR_CAPTURE;
          // Data in captured on the rising test clock edge
          `ST_SHIFT_IR: ir_shift_q <= {tdi_s, ir_shift_q[`IR_W-1:1]};
          `ST_UPD_IR: ir_q <= ir_shift_q;
          `ST_CAP_DR:
          begin
            id_shift_q <= ID_WORD;
            bypass_q <= 1'b0;
          end
          `ST_SHIFT_DR:
          begin
            if (sel_id)
              id_shift_q <= {tdi_s, id_shift_q[`ID_W-1:1]};
            else
              bypass_q <= tdi_s;
          end
          default: ir_q <= ir_q;
        endcase
      end
    end
  end

  // Data out changes on the falling test clock edge, driven in shifts only
  always @(posedge clk_sys)
  begin
    if (!nrst || !trst_s)
    begin
      test_data_out <= 1'b0;
      test_data_out_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      if (state_q == `ST_SHIFT_IR)
      begin
        test_data_out <= ir_shift_q[0];
        test_data_out_oe <= 1'b1;
      end
      else if (state_q == `ST_SHIFT_DR)
      begin
        test_data_out <= sel_id ? id_shift_q[0] : bypass_q;
        test_data_out_oe <= 1'b1;
      end
      else
        test_data_out_oe <= 1'b0;
    end
  end

endmodule

module dual_test_ports #(
  parameter [`ID_W-1:0] MAPPER_ID = 32'h00000001, // Arbitrary value
  parameter [`ID_W-1:0] XCVR_ID = 32'h00000003 // Arbitrary value
) (
  input wire clk_sys,
  input wire nrst,
  input wire mapper_test_clock,
  input wire mapper_test_mode_select,
  input wire mapper_test_data_in,
  input wire mapper_test_reset,
  output wire mapper_test_data_out,
  output wire mapper_test_data_out_oe,
  output wire mapper_id_mode,
  input wire transceiver_test_clock,
  input wire transceiver_test_mode_select,
  input wire transceiver_test_data_in,
  input wire transceiver_test_reset,
  output wire transceiver_test_data_out,
  output wire transceiver_test_data_out_oe,
  output wire transceiver_id_mode
);

  // Mapper port, fully separate controller
  test_port_tap #(.ID_WORD(MAPPER_ID)) mapper_port (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .test_clock(mapper_test_clock),
    .test_mode_select(mapper_test_mode_select),
    .test_data_in(mapper_test_data_in),
    .test_reset(mapper_test_reset),
    .test_data_out(mapper_test_data_out),
    .test_data_out_oe(mapper_test_data_out_oe),
    .id_mode(mapper_id_mode)
  );

  // Transceiver port, fully separate controller
  test_port_tap #(.ID_WORD(XCVR_ID)) transceiver_port (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .test_clock(transceiver_test_clock),
    .test_mode_select(transceiver_test_mode_select),
    .test_data_in(transceiver_test_data_in),
    .test_reset(transceiver_test_reset),
    .test_data_out(transceiver_test_data_out),
    .test_data_out_oe(transceiver_test_data_out_oe),
    .id_mode(transceiver_id_mode)
  );

endmodule

// ### verification/test_ports_assertions.sv
/* Checker on the test port pins.
   Assumes test clocks under a quarter of clk_sys. */
`timescale 1ns/1ns
module test_ports_chk (
  input wire clk_sys,
  input wire nrst,
  input wire mapper_test_clock,
  input wire mapper_test_reset,
  input wire mapper_test_data_out_oe,
  input wire mapper_id_mode,
  input wire transceiver_test_clock,
  input wire transceiver_test_reset,
  input wire transceiver_test_data_out_oe,
  input wire transceiver_id_mode
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Held test reset clears a port with no test clock
  m_rst_clr_a: assert property (!mapper_test_reset [*4]
    |-> !mapper_id_mode && !mapper_test_data_out_oe) else $error("m clr");
  x_rst_clr_a: assert property (!transceiver_test_reset [*4]
    |-> !transceiver_id_mode && !transceiver_test_data_out_oe)
    else $error("x clr");
  // Rising test reset enters ID mode, which then holds
  m_id_set_a: assert property ($rose(mapper_test_reset)
    |-> ##[2:5] mapper_id_mode) else $error("m id");
  x_id_set_a: assert property ($rose(transceiver_test_reset)
    |-> ##[2:5] transceiver_id_mode) else $error("x id");
  m_id_hold_a: assert property (mapper_id_mode && mapper_test_reset
    |=> mapper_id_mode) else $error("m hold");
  x_id_hold_a: assert property (transceiver_id_mode
    && transceiver_test_reset |=> transceiver_id_mode) else $error("x hold");
  // Driver turns on only after a falling test clock
  m_oe_fall_a: assert property ($rose(mapper_test_data_out_oe)
    |-> !$past(mapper_test_clock, 2) && mapper_test_reset) else $error("m oe");
  x_oe_fall_a: assert property ($rose(transceiver_test_data_out_oe)
    |-> !$past(transceiver_test_clock, 2)) else $error("x oe");
  cover property ($rose(mapper_test_data_out_oe));
  cover property ($rose(transceiver_test_data_out_oe));
  cover property ($rose(transceiver_id_mode));
  cover property ($rose(mapper_id_mode));
endmodule
bind dual_test_ports test_ports_chk u_test_ports_chk (
  .clk_sys(clk_sys), .nrst(nrst), .mapper_test_clock(mapper_test_clock),
  .mapper_test_reset(mapper_test_reset), .mapper_id_mode(mapper_id_mode),
  .mapper_test_data_out_oe(mapper_test_data_out_oe),
  .transceiver_test_clock(transceiver_test_clock),
  .transceiver_test_reset(transceiver_test_reset),
  .transceiver_test_data_out_oe(transceiver_test_data_out_oe),
  .transceiver_id_mode(transceiver_id_mode));

// ### verification/test_ctl_model.sv
/* Outside boundary-scan controller for one port.
   Assumes tasks are entered just after a clk_sys edge. */
`timescale 1ns/1ns
module test_ctl_model (
  input wire clk_sys,
  input wire tdo,
  output reg tck,
  output reg tms,
  output reg tdi,
  output reg trst
);
  // Clock still, pulled-up lines high, reset low
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst = 1'b0;
  end
  // Drive the test reset level
  task set_rst(input v);
    begin
      @(posedge clk_sys);
      #1 trst = v;
    end
  endtask
  // One 8-cycle test clock period; data out taken at the rise
  task cyc(input m, input d, output q);
    begin
      tms = m;
      tdi = d;
      repeat (2) @(posedge clk_sys);
      #1 tck = 1'b1;
      q = tdo;
      repeat (4) @(posedge clk_sys);
      #1 tck = 1'b0;
      tdi = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
    end
  endtask
endmodule

// ### verification/tb_top.sv
/* Bench for dual_test_ports with two controller models.
   Assumes each task starts just after a clk_sys edge. */
`timescale 1ns/1ns
module tb_top;
  localparam [31:0] M_ID = 32'h5a0f0c31; // Arbitrary
  localparam [31:0] X_ID = 32'h0c33a5e7; // Arbitrary
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  wire [1:0] tck, tms, tdi, trst, out, oe, idm, tdo;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer tick = 0;
  integer i;
  reg [31:0] word;
  reg q;
  // Data out floats while its driver is off
  assign tdo = {oe[1] ? out[1] : 1'bz, oe[0] ? out[0] : 1'bz};
  initial
    forever #20 clk_sys = ~clk_sys;
  dual_test_ports #(.MAPPER_ID(M_ID), .XCVR_ID(X_ID)) u_dual_test_ports (
    .clk_sys(clk_sys), .nrst(nrst), .mapper_test_clock(tck[0]),
    .mapper_test_mode_select(tms[0]), .mapper_test_data_in(tdi[0]),
    .mapper_test_reset(trst[0]), .mapper_test_data_out(out[0]),
    .mapper_test_data_out_oe(oe[0]), .mapper_id_mode(idm[0]),
    .transceiver_test_clock(tck[1]), .transceiver_test_mode_select(tms[1]),
    .transceiver_test_data_in(tdi[1]), .transceiver_test_reset(trst[1]),
    .transceiver_test_data_out(out[1]), .transceiver_id_mode(idm[1]),
    .transceiver_test_data_out_oe(oe[1]));
  test_ctl_model u_test_ctl_model_m (.clk_sys(clk_sys), .tdo(tdo[0]),
    .tck(tck[0]), .tms(tms[0]), .tdi(tdi[0]), .trst(trst[0]));
  test_ctl_model u_test_ctl_model_x (.clk_sys(clk_sys), .tdo(tdo[1]),
    .tck(tck[1]), .tms(tms[1]), .tdi(tdi[1]), .trst(trst[1]));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("mismatch %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task rst(input p, input v);
    if (p)
      u_test_ctl_model_x.set_rst(v);
    else
      u_test_ctl_model_m.set_rst(v);
  endtask
  // Run n test clocks, mode bits ms, data din; gather data out
  task seq(input p, input [31:0] ms, input [31:0] din, input integer n);
    integer k;
    begin
      word = 32'h0;
      for (k = 0; k < n; k = k + 1)
      begin
        if (p)
          u_test_ctl_model_x.cyc(ms[k], din[k], q);
        else
          u_test_ctl_model_m.cyc(ms[k], din[k], q);
        word[k] = q;
      end
    end
  endtask
  task t_id(input p);
    begin
      rst(p, 1'b0);
      rst(p, 1'b1);
      repeat (6) @(posedge clk_sys);
      #1 check(idm, {p, ~p});
      seq(p, 32'h2, 32'hffffffff, 4);
      seq(p, 32'h80000000, 32'h0, 32);
      check(word, p ? X_ID : M_ID);
      seq(p, 32'h1, 32'hffffffff, 2);
    end
  endtask
  task t_byp(input p);
    begin
      seq(p, 32'h3, 32'hf, 4);
      seq(p, 32'h8, 32'hf, 4);
      check(word[3:0], 4'h1);
      seq(p, 32'h5, 32'hf, 5);
      seq(p, 32'h4, 32'h3, 3);
      check(word[2:0], 3'h6);
      seq(p, 32'h5f, 32'hffffffff, 9);
      seq(p, 32'h0, 32'h0, 8);
      check(word[7:0], p ? X_ID[7:0] : M_ID[7:0]);
      // Exit1, Pause, Exit2 and back to Shift: no bit lost on the way
      seq(p, 32'h5, 32'h0, 5);
      check({word[4], word[0]}, p ? X_ID[9:8] : M_ID[9:8]);
    end
  endtask
  // Drop test reset in mid-shift with the test clock stopped
  task t_rst(input p);
    begin
      repeat (2) @(posedge clk_sys);
      #1 check(oe[p], 1'b1);
      rst(p, 1'b0);
      repeat (4) @(posedge clk_sys);
      #1 check({oe[p], idm[p]}, 2'b0);
    end
  endtask
  task test_done;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk_sys)
  begin
    tick = tick + 1;
    if (tick == 4000)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1 nrst = 1'b1;
    for (i = 0; i < 2; i = i + 1)
    begin
      t_id(i[0]);
      t_byp(i[0]);
      t_rst(i[0]);
    end
    test_done;
  end
endmodule
